// file: cvd_pkg.sv
// Constants, types and register map for the capacitive divider sequencer control block.
// Assumes a 32-bit APB master on the same clock as the sequencer.
`default_nettype none
package cvd_pkg;

   localparam int unsigned CLOCK_MHZ = 125;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned ADDR_WIDTH = 8;

   // Register byte offsets.
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] STAGE_STATUS_OFFSET = 8'h04;
   localparam logic [7:0] PRECHARGE_OFFSET = 8'h08;
   localparam logic [7:0] ACQUISITION_OFFSET = 8'h0C;
   localparam logic [7:0] GUARD_OFFSET = 8'h10;
   localparam logic [7:0] CAP_OFFSET = 8'h14;
   localparam logic [7:0] RESULT0_HIGH_OFFSET = 8'h18;
   localparam logic [7:0] RESULT0_LOW_OFFSET = 8'h1C;
   localparam logic [7:0] RESULT1_HIGH_OFFSET = 8'h20;
   localparam logic [7:0] RESULT1_LOW_OFFSET = 8'h24;

   // Control register fields.
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_START_BIT = 1;
   localparam int unsigned CTRL_DOUBLE_BIT = 2;
   localparam int unsigned CTRL_INVERT_BIT = 3;
   localparam int unsigned CTRL_RC_BIT = 4;
   localparam int unsigned CTRL_JUSTIFY_BIT = 7;

   // Status, guard and capacitor fields.
   localparam int unsigned STAT_PAIR_BIT = 2;
   localparam int unsigned GUARD_B_ENABLE_BIT = 7;
   localparam int unsigned GUARD_A_ENABLE_BIT = 6;
   localparam int unsigned GUARD_POLARITY_BIT = 5;
   localparam int unsigned TIME_WIDTH = 7;
   localparam int unsigned CAP_WIDTH = 3;
   localparam int unsigned RESULT_WIDTH = 10;
   localparam logic [4:0] CAP_STEP_PF = 5'h04;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [TIME_WIDTH-1:0] TIME_ZERO = 7'h00;

   typedef enum logic [1:0] {
      CVD_IDLE = 2'b00,
      CVD_PRECHARGE = 2'b01,
      CVD_ACQUIRE = 2'b10,
      CVD_CONVERT = 2'b11
   } cvd_stage_type;

endpackage : cvd_pkg

`default_nettype wire

// file: cvd_sequencer.sv
// Sequencer control, status, guard ring drive and result formatting, with an APB register slave.
// Assumes the analog converter and the instruction-cycle strobe run on the same clock; the
// dedicated RC clock arrives from another domain and is synchronised here.
`timescale 1ns/10ps
`default_nettype none

module cvd_sequencer (
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_enable,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cvd_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [cvd_pkg::DATA_WIDTH-1:0] pwdata,
   output logic [cvd_pkg::DATA_WIDTH-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timing sources.
   input wire logic instr_tick,
   input wire logic dedicated_rc_clock,
   // Analog converter handshake.
   output logic convert_start,
   input wire logic convert_done,
   input wire logic [cvd_pkg::RESULT_WIDTH-1:0] conversion_result,
   // Guard ring pins.
   output logic guard_a_pin,
   output logic guard_a_oe_n,
   output logic guard_b_pin,
   output logic guard_b_oe_n,
   // Sample capacitor switch and stage view.
   output logic [cvd_pkg::CAP_WIDTH-1:0] extra_cap_select,
   output logic [4:0] extra_cap_pf,
   output logic [1:0] stage_status_field,
   output logic result_pair_indicator
);
   import cvd_pkg::*;

   typedef struct packed {
      logic [7:0] control;
      logic [TIME_WIDTH-1:0] precharge_time_field;
      logic [TIME_WIDTH-1:0] acquisition_time_field;
      logic [2:0] guard_ring_control;
      logic [CAP_WIDTH-1:0] cap_code;
      logic [7:0] res0_high;
      logic [7:0] res0_low;
      logic [7:0] res1_high;
      logic [7:0] res1_low;
      cvd_stage_type stage;
      logic second_pass;
      logic [TIME_WIDTH-1:0] count;
      logic start_pulse;
      logic guard_a;
      logic guard_b;
      logic rc_meta;
      logic rc_sync;
      logic rc_prev;
      logic ack;
      logic [DATA_WIDTH-1:0] rdata;
      logic err;
   } cvd_state_type;

   cvd_state_type state;
   cvd_state_type next_state;

   // Address decode used by both the read path and the write path.
   function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] a);
      unique case (a)
         CONTROL_OFFSET, STAGE_STATUS_OFFSET, PRECHARGE_OFFSET, ACQUISITION_OFFSET,
         GUARD_OFFSET, CAP_OFFSET, RESULT0_HIGH_OFFSET, RESULT0_LOW_OFFSET,
         RESULT1_HIGH_OFFSET, RESULT1_LOW_OFFSET: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction : addr_mapped

   // Result layout for the high byte.
   function automatic logic [7:0] format_high(input logic right, input logic [RESULT_WIDTH-1:0] r);
      if (right) begin
         format_high = {6'h00, r[9:8]};
      end else begin
         format_high = r[9:2];
      end
   endfunction : format_high

   // Result layout for the low byte.
   function automatic logic [7:0] format_low(input logic right, input logic [RESULT_WIDTH-1:0] r);
      if (right) begin
         format_low = r[7:0];
      end else begin
         format_low = {r[1:0], 6'h00};
      end
   endfunction : format_low

   // First stage to enter from a given point, skipping stages programmed to zero time.
   function automatic cvd_stage_type first_stage(input logic [TIME_WIDTH-1:0] pre,
                                                 input logic [TIME_WIDTH-1:0] acq);
      if (pre != TIME_ZERO) begin
         first_stage = CVD_PRECHARGE;
      end else if (acq != TIME_ZERO) begin
         first_stage = CVD_ACQUIRE;
      end else begin
         first_stage = CVD_CONVERT;
      end
   endfunction : first_stage

   logic enabled;
   logic running;
   logic tick;
   logic eff_polarity;
   logic access;
   logic wr_en;
   logic [7:0] wbyte;
   logic begin_sequence;
   cvd_stage_type entry_stage;

   always_comb begin
      next_state = state;
      enabled = state.control[CTRL_ENABLE_BIT];
      running = state.control[CTRL_START_BIT];
      // Only the second flop of the synchroniser feeds the edge detector.
      tick = state.control[CTRL_RC_BIT] ? (state.rc_sync & ~state.rc_prev) : instr_tick;
      eff_polarity = state.guard_ring_control[GUARD_POLARITY_BIT - 5]
                     ^ (state.second_pass & state.control[CTRL_DOUBLE_BIT]
                        & state.control[CTRL_INVERT_BIT]);
      access = psel & penable & state.ack;
      wr_en = access & pwrite & ~state.err;
      wbyte = pwdata[7:0];
      begin_sequence = 1'b0;
      entry_stage = first_stage(state.precharge_time_field, state.acquisition_time_field);

      next_state.rc_meta = dedicated_rc_clock;
      next_state.rc_sync = state.rc_meta;
      next_state.rc_prev = state.rc_sync;
      next_state.start_pulse = 1'b0;

      // The slave answers on the second access cycle so that read data comes from a flop.
      if (psel & penable & ~state.ack) begin
         next_state.ack = 1'b1;
         next_state.err = ~addr_mapped(paddr);
         next_state.rdata = '0;
         unique case (paddr)
            CONTROL_OFFSET: next_state.rdata[7:0] = state.control;
            STAGE_STATUS_OFFSET: next_state.rdata[7:0] = {5'h00, state.second_pass & running, state.stage};
            PRECHARGE_OFFSET: next_state.rdata[7:0] = {1'b0, state.precharge_time_field};
            ACQUISITION_OFFSET: next_state.rdata[7:0] = {1'b0, state.acquisition_time_field};
            GUARD_OFFSET: next_state.rdata[7:0] = {state.guard_ring_control, 5'h00};
            CAP_OFFSET: next_state.rdata[7:0] = {5'h00, state.cap_code};
            RESULT0_HIGH_OFFSET: next_state.rdata[7:0] = state.res0_high;
            RESULT0_LOW_OFFSET: next_state.rdata[7:0] = state.res0_low;
            RESULT1_HIGH_OFFSET: next_state.rdata[7:0] = state.res1_high;
            RESULT1_LOW_OFFSET: next_state.rdata[7:0] = state.res1_low;
            default: next_state.rdata = '0;
         endcase
      end else begin
         next_state.ack = 1'b0;
      end

      // Software writes; the status register ignores writes because hardware owns it.
      if (wr_en) begin
         unique case (paddr)
            CONTROL_OFFSET: begin
               next_state.control = {wbyte[7], 2'b00, wbyte[4:0]};
               // Start is only taken while idle and enabled; clearing it aborts the sequence.
               if (wbyte[CTRL_START_BIT] & wbyte[CTRL_ENABLE_BIT] & ~running) begin
                  begin_sequence = 1'b1;
               end else if (~wbyte[CTRL_START_BIT] | ~wbyte[CTRL_ENABLE_BIT]) begin
                  next_state.control[CTRL_START_BIT] = 1'b0;
                  next_state.stage = CVD_IDLE;
                  next_state.second_pass = 1'b0;
               end else begin
                  next_state.control[CTRL_START_BIT] = running;
               end
            end
            PRECHARGE_OFFSET: next_state.precharge_time_field = wbyte[TIME_WIDTH-1:0];
            ACQUISITION_OFFSET: next_state.acquisition_time_field = wbyte[TIME_WIDTH-1:0];
            GUARD_OFFSET: next_state.guard_ring_control = wbyte[7:5];
            CAP_OFFSET: next_state.cap_code = wbyte[CAP_WIDTH-1:0];
            RESULT0_HIGH_OFFSET: next_state.res0_high = wbyte;
            RESULT0_LOW_OFFSET: next_state.res0_low = wbyte;
            RESULT1_HIGH_OFFSET: next_state.res1_high = wbyte;
            RESULT1_LOW_OFFSET: next_state.res1_low = wbyte;
            default: next_state.err = state.err;
         endcase
      end

      // Sequencer; runs after the bus so a result load beats a same-cycle software write.
      // A same-cycle abort still wins, or the stage would stick with start/done clear.
      if (running & enabled & next_state.control[CTRL_START_BIT]) begin
         unique case (state.stage)
            CVD_PRECHARGE: begin
               if (tick) begin
                  if (state.count == TIME_WIDTH'(1)) begin
                     if (state.acquisition_time_field != TIME_ZERO) begin
                        next_state.stage = CVD_ACQUIRE;
                        next_state.count = state.acquisition_time_field;
                        next_state.guard_a = ~state.guard_a;
                     end else begin
                        next_state.stage = CVD_CONVERT;
                        next_state.start_pulse = 1'b1;
                     end
                  end else begin
                     next_state.count = state.count - TIME_WIDTH'(1);
                  end
               end
            end
            CVD_ACQUIRE: begin
               if (tick) begin
                  if (state.count == TIME_WIDTH'(1)) begin
                     next_state.stage = CVD_CONVERT;
                     next_state.start_pulse = 1'b1;
                  end else begin
                     next_state.count = state.count - TIME_WIDTH'(1);
                  end
               end
            end
            CVD_CONVERT: begin
               if (convert_done) begin
                  if (state.second_pass) begin
                     next_state.res1_high = format_high(state.control[CTRL_JUSTIFY_BIT], conversion_result);
                     next_state.res1_low = format_low(state.control[CTRL_JUSTIFY_BIT], conversion_result);
                  end else begin
                     next_state.res0_high = format_high(state.control[CTRL_JUSTIFY_BIT], conversion_result);
                     next_state.res0_low = format_low(state.control[CTRL_JUSTIFY_BIT], conversion_result);
                  end
                  if (state.control[CTRL_DOUBLE_BIT] & ~state.second_pass) begin
                     next_state.second_pass = 1'b1;
                     begin_sequence = 1'b1;
                  end else begin
                     next_state.control[CTRL_START_BIT] = 1'b0;
                     next_state.stage = CVD_IDLE;
                     next_state.second_pass = 1'b0;
                  end
               end
            end
            default: next_state.stage = CVD_IDLE;
         endcase
      end else if (~enabled) begin
         next_state.control[CTRL_START_BIT] = 1'b0;
         next_state.stage = CVD_IDLE;
         next_state.second_pass = 1'b0;
      end

      // Entry into a new pass; the polarity uses the pass that is about to run.
      if (begin_sequence) begin
         next_state.control[CTRL_START_BIT] = 1'b1;
         next_state.stage = entry_stage;
         next_state.start_pulse = (entry_stage == CVD_CONVERT);
         next_state.guard_a = state.guard_ring_control[GUARD_POLARITY_BIT - 5]
                              ^ (next_state.second_pass & state.control[CTRL_DOUBLE_BIT]
                                 & state.control[CTRL_INVERT_BIT]);
         next_state.guard_b = next_state.guard_a;
         if (entry_stage == CVD_PRECHARGE) begin
            next_state.count = state.precharge_time_field;
         end else begin
            next_state.count = state.acquisition_time_field;
         end
         if (entry_stage == CVD_ACQUIRE) begin
            next_state.guard_a = ~next_state.guard_a;
         end
      end else if (state.stage == CVD_IDLE & ~begin_sequence) begin
         next_state.guard_a = eff_polarity;
         next_state.guard_b = eff_polarity;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else if (clock_enable) begin
         state <= next_state;
      end
   end

   // Handshake outputs are combinational from flops; data outputs are flops.
   assign pready = state.ack;
   assign pslverr = state.ack & state.err;
   assign prdata = state.rdata;
   assign convert_start = state.start_pulse;
   assign stage_status_field = state.stage;
   assign result_pair_indicator = state.second_pass & state.control[CTRL_START_BIT];
   assign guard_a_pin = state.guard_a;
   assign guard_b_pin = state.guard_b;
   assign guard_a_oe_n = ~(state.guard_ring_control[GUARD_A_ENABLE_BIT - 5]
                           & state.control[CTRL_ENABLE_BIT]);
   assign guard_b_oe_n = ~(state.guard_ring_control[GUARD_B_ENABLE_BIT - 5]
                           & state.control[CTRL_ENABLE_BIT]);
   assign extra_cap_select = state.cap_code;
   assign extra_cap_pf = 5'(CAP_STEP_PF * state.cap_code);

endmodule : cvd_sequencer

`default_nettype wire

// file: cvd_properties.sv
// Concurrent checks on the ports of the sequencer top module.
// Assumes one clock domain and the asynchronous active-high reset of the design.
`timescale 1ns/10ps
`default_nettype none
module cvd_properties (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Register bus answer.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   // Sequencer view.
   input wire logic convert_start,
   input wire logic guard_a_pin,
   input wire logic guard_a_oe_n,
   input wire logic guard_b_oe_n,
   input wire logic [cvd_pkg::CAP_WIDTH-1:0] extra_cap_select,
   input wire logic [4:0] extra_cap_pf,
   input wire logic [1:0] stage_status_field,
   input wire logic result_pair_indicator
);
   import cvd_pkg::*;
   // Drive enables come straight from registers, so they may only move after a completed write.
   logic write_done;
   assign write_done = psel & penable & pwrite & pready;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_PAIR_IDLE: assert property (stage_status_field == CVD_IDLE |-> !result_pair_indicator)
      else $error("pair indicator high while idle");
   AST_PAIR_RISE: assert property ($rose(result_pair_indicator) |-> $past(stage_status_field) == CVD_CONVERT)
      else $error("pair indicator rose outside a conversion end");
   AST_START_IN_CONV: assert property (convert_start |-> stage_status_field == CVD_CONVERT)
      else $error("converter started outside conversion stage");
   AST_START_PULSE: assert property (convert_start |=> !convert_start)
      else $error("converter start longer than one cycle");
   AST_NO_ACQ_TO_PRE: assert property ($past(stage_status_field) == CVD_ACQUIRE |-> stage_status_field != CVD_PRECHARGE)
      else $error("acquisition went back to pre-charge");
   AST_PRE_ENTRY: assert property (stage_status_field == CVD_PRECHARGE && $past(stage_status_field) != CVD_PRECHARGE
      |-> $past(stage_status_field) inside {CVD_IDLE, CVD_CONVERT})
      else $error("pre-charge entered from a wrong stage");
   AST_GUARD_A_TOGGLE: assert property (stage_status_field == CVD_ACQUIRE && $past(stage_status_field) == CVD_PRECHARGE
      |-> guard_a_pin != $past(guard_a_pin))
      else $error("guard A did not toggle at acquisition start");
   AST_CAP_PF: assert property (extra_cap_pf == {extra_cap_select, 2'h0})
      else $error("capacitor size not four times the code");
   AST_GUARD_A_OE: assert property ($changed(guard_a_oe_n) |-> $past(write_done))
      else $error("guard A drive changed without a write");
   AST_GUARD_B_OE: assert property ($changed(guard_b_oe_n) |-> $past(write_done))
      else $error("guard B drive changed without a write");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error response without ready");
endmodule : cvd_properties
bind cvd_sequencer cvd_properties u_props (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .convert_start(convert_start),
   .guard_a_pin(guard_a_pin), .guard_a_oe_n(guard_a_oe_n), .guard_b_oe_n(guard_b_oe_n),
   .extra_cap_select(extra_cap_select), .extra_cap_pf(extra_cap_pf),
   .stage_status_field(stage_status_field), .result_pair_indicator(result_pair_indicator));
`default_nettype wire

// file: cvd_converter_model.sv
// Behavioural analog converter: answers each start with a one-cycle done and a result.
// Assumes the sequencer clock; results alternate between the base value and its inverse.
`timescale 1ns/10ps
`default_nettype none
module cvd_converter_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Converter handshake.
   input wire logic convert_start,
   output logic convert_done,
   output logic [cvd_pkg::RESULT_WIDTH-1:0] conversion_result,
   // Bench controls.
   input wire logic [7:0] answer_delay,
   input wire logic [cvd_pkg::RESULT_WIDTH-1:0] result_base
);
   logic [7:0] wait_count;
   logic busy;
   logic odd;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         odd <= 1'b0;
         wait_count <= 8'h00;
         convert_done <= 1'b0;
      end else begin
         convert_done <= 1'b0;
         if (convert_start) begin
            busy <= 1'b1;
            wait_count <= answer_delay;
         end else if (busy && wait_count == 8'h00) begin
            busy <= 1'b0;
            odd <= ~odd;
            convert_done <= 1'b1;
         end else if (busy) begin
            wait_count <= wait_count - 8'h01;
         end
      end
   end
   // Outside done the line shows the inverse, so a late sample cannot pass for the result.
   assign conversion_result = (convert_done == odd) ? result_base : ~result_base;
endmodule : cvd_converter_model
`default_nettype wire

// file: cvd_sequencer_tb.sv
// Self-checking bench for the sequencer: register access, guard drive and conversion runs.
// Assumes the converter model answers each start; instruction ticks come every four clocks.
`timescale 1ns/10ps
`default_nettype none
module cvd_sequencer_tb;
   import cvd_pkg::*;
   localparam logic [9:0] BASE = 10'h2D6;
   logic clock = 1'b0, rst = 1'b1, clock_enable = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00, answer_delay = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic instr_tick = 1'b0, dedicated_rc_clock = 1'b0, convert_start, convert_done, conv_odd = 1'b0;
   logic [9:0] conversion_result;
   logic guard_a_pin, guard_a_oe_n, guard_b_pin, guard_b_oe_n, result_pair_indicator;
   logic [2:0] extra_cap_select, rc_count = 3'h0;
   logic [4:0] extra_cap_pf;
   logic [1:0] stage_status_field, tick_count = 2'h0;
   int miscompares = 0, num_checks = 0;
   cvd_sequencer uut (.clock(clock), .rst(rst), .clock_enable(clock_enable), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_tick(instr_tick), .dedicated_rc_clock(dedicated_rc_clock), .convert_start(convert_start),
      .convert_done(convert_done), .conversion_result(conversion_result), .guard_a_pin(guard_a_pin),
      .guard_a_oe_n(guard_a_oe_n), .guard_b_pin(guard_b_pin), .guard_b_oe_n(guard_b_oe_n),
      .extra_cap_select(extra_cap_select), .extra_cap_pf(extra_cap_pf),
      .stage_status_field(stage_status_field), .result_pair_indicator(result_pair_indicator));
   cvd_converter_model conv (.clock(clock), .rst(rst), .convert_start(convert_start),
      .convert_done(convert_done), .conversion_result(conversion_result), .answer_delay(answer_delay),
      .result_base(BASE));
   initial forever #4 clock = ~clock;
   always @(posedge clock) begin
      tick_count <= tick_count + 2'h1;
      instr_tick <= (tick_count == 2'h3);
      rc_count <= (rc_count == 3'h5) ? 3'h0 : rc_count + 3'h1;
      if (rc_count == 3'h5) dedicated_rc_clock <= ~dedicated_rc_clock;
      if (convert_done === 1'b1) conv_odd <= ~conv_odd;
   end
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 50, "bus answer missing");
   endtask : apb_xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb_xfer(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe, input string msg);
      logic [31:0] r;
      logic e;
      apb_xfer(1'b0, a, 32'h0, r, e);
      chk(r === x && e === xe, msg);
   endtask : rd_chk
   function automatic logic [15:0] fmt(input logic [9:0] r, input logic right);
      return right ? {6'h00, r[9:8], r[7:0]} : {r[9:2], r[1:0], 6'h00};
   endfunction : fmt
   task automatic reg_test();
      for (int k = 0; k < 6; k++) rd_chk(8'(4 * k), 32'h0, 1'b0, "reset value");
      rd_chk(8'h28, 32'h0, 1'b1, "unmapped read");
      wr(STAGE_STATUS_OFFSET, 32'hFF);
      rd_chk(STAGE_STATUS_OFFSET, 32'h0, 1'b0, "status write");
      wr(PRECHARGE_OFFSET, 32'hFFFF_FFFF);
      rd_chk(PRECHARGE_OFFSET, 32'h7F, 1'b0, "pre-charge width");
      wr(ACQUISITION_OFFSET, 32'hFF);
      rd_chk(ACQUISITION_OFFSET, 32'h7F, 1'b0, "acquisition width");
      wr(GUARD_OFFSET, 32'hFF);
      rd_chk(GUARD_OFFSET, 32'hE0, 1'b0, "guard bits");
      for (int k = 0; k < 8; k++) begin
         wr(CAP_OFFSET, 32'(k));
         @(posedge clock);
         chk(extra_cap_select === 3'(k) && extra_cap_pf === 5'(4 * k), "capacitor code");
      end
   endtask : reg_test
   task automatic guard_oe_test();
      for (int k = 0; k < 4; k++) begin
         wr(GUARD_OFFSET, 32'(k * 64));
         wr(CONTROL_OFFSET, 32'h1);
         @(posedge clock);
         chk(guard_b_oe_n === !k[1] && guard_a_oe_n === !k[0], "guard drive");
         wr(CONTROL_OFFSET, 32'h0);
         @(posedge clock);
         chk(guard_b_oe_n === 1'b1 && guard_a_oe_n === 1'b1, "guard drive off");
      end
   endtask : guard_oe_test
   task automatic run(input logic [6:0] pre, input logic [6:0] acq, input logic [7:0] ctrl,
                      input logic [7:0] grd, input int per);
      int n, dones, bad;
      int len[4];
      logic seen;
      logic [9:0] v;
      logic [15:0] e;
      n = 0;
      dones = 0;
      bad = 0;
      len = '{default: 0};
      seen = 1'b0;
      v = conv_odd ? ~BASE : BASE;
      answer_delay <= {1'b0, acq};
      wr(PRECHARGE_OFFSET, {25'h0, pre});
      wr(ACQUISITION_OFFSET, {25'h0, acq});
      wr(GUARD_OFFSET, {24'h0, grd});
      wr(RESULT0_HIGH_OFFSET, 32'hFF);
      wr(RESULT0_LOW_OFFSET, 32'hFF);
      wr(CONTROL_OFFSET, {24'h0, ctrl});
      do begin
         @(posedge clock);
         n++;
         if (stage_status_field !== CVD_IDLE) begin
            seen = 1'b1;
            if (result_pair_indicator !== dones[0]) bad++;
         end
         if (convert_done === 1'b1) dones++;
         else if (stage_status_field === CVD_PRECHARGE || stage_status_field === CVD_ACQUIRE) begin
            len[2 * dones + int'(stage_status_field[1])]++;
            if (stage_status_field === CVD_PRECHARGE && len[2 * dones] == 1)
               chk({guard_a_pin, guard_b_pin} === {2{grd[5] ^ (dones == 1 && ctrl[3])}}, "guard start");
         end
      end while (n < 4000 && !(seen && stage_status_field === CVD_IDLE));
      chk(n < 4000, "run did not end");
      chk(dones == (ctrl[2] ? 2 : 1) && bad == 0, "passes and pair indicator");
      for (int p = 0; p <= int'(ctrl[2]); p++) begin
         chk(pre == 0 ? len[2 * p] == 0 : len[2 * p] inside {[per * (pre - 1):per * pre + 3]}, "pre");
         chk(acq == 0 ? len[2 * p + 1] == 0 : len[2 * p + 1] inside {[per * (acq - 1):per * acq + 3]}, "acq");
      end
      e = fmt(v, ctrl[7]);
      rd_chk(RESULT0_HIGH_OFFSET, {24'h0, e[15:8]}, 1'b0, "first high");
      rd_chk(RESULT0_LOW_OFFSET, {24'h0, e[7:0]}, 1'b0, "first low");
      e = fmt(~v, ctrl[7]);
      if (ctrl[2]) rd_chk(RESULT1_HIGH_OFFSET, {24'h0, e[15:8]}, 1'b0, "second high");
      if (ctrl[2]) rd_chk(RESULT1_LOW_OFFSET, {24'h0, e[7:0]}, 1'b0, "second low");
      rd_chk(CONTROL_OFFSET, {24'h0, ctrl & 8'hFD}, 1'b0, "start bit at end");
      rd_chk(GUARD_OFFSET, {24'h0, grd & 8'hE0}, 1'b0, "stored polarity");
      chk(guard_a_oe_n === !grd[6] && guard_b_oe_n === !grd[7], "guard held");
   endtask : run
   // Freezes a started pre-charge, then aborts it by clearing start.
   task automatic freeze_test();
      wr(PRECHARGE_OFFSET, 32'h1);
      wr(CONTROL_OFFSET, 32'h3);
      clock_enable <= 1'b0;
      repeat (20) @(posedge clock);
      chk(stage_status_field === CVD_PRECHARGE && convert_start === 1'b0, "frozen stage");
      clock_enable <= 1'b1;
      wr(CONTROL_OFFSET, 32'h1);
      @(posedge clock);
      chk(stage_status_field === CVD_IDLE && result_pair_indicator === 1'b0, "abort to idle");
      rd_chk(CONTROL_OFFSET, 32'h1, 1'b0, "start cleared by abort");
   endtask : freeze_test
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #300000;
      miscompares++;
      report_and_stop();
   end
   // Software is taken to have set each enabled guard pin to output.
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      reg_test();
      guard_oe_test();
      run(7'h03, 7'h02, 8'h03, 8'hE0, 4);
      run(7'h00, 7'h02, 8'h83, 8'h40, 4);
      run(7'h02, 7'h00, 8'h03, 8'h80, 4);
      run(7'h02, 7'h01, 8'h13, 8'h20, 12);
      run(7'h01, 7'h01, 8'h0F, 8'hE0, 4);
      run(7'h00, 7'h00, 8'h87, 8'h00, 4);
      run(7'h7F, 7'h7F, 8'h03, 8'h20, 4);
      freeze_test();
      report_and_stop();
   end
endmodule : cvd_sequencer_tb
`default_nettype wire
